//--- src/bdsl_device.sv
// target end of the single-wire debug link
// Functional notes
// (R1) falling edge starts bit; sample at ten
// (R2) host returns high by eight for one
// (R3) host holds start low two cycles
// (R4) device speedup pulse at seven for one
// (R5) host samples returned bit near ten
// (R6) low over 128 means timing request
// (R7) timing request waits forever for rise
// (R8) shorter low is a data bit
// (R9) no edge in 512 soft-resets link; the code does so only with a partial byte or read data pending
// (R10) uncollected read data dropped after 512
// (R11) step with pending interrupt only stacks
// (R12) step over stop/wait finishes on exit
// (R13) in stop/wait all but enter-debug work; the code also ignores step while low_power is set
// (R14) system stop blocks every command
// (R15) step over low-power gets no ack
// (R16) commands during low-power still acknowledged
// (R17) system stop clears handshake enable
// (R18) host never steps software break instruction
// (R19) drive low or release; pull-up returns; the code drives the line high for its speedup pulses and the timing answer
module bdsl_device (
  input wire logic clk_sys,
  input wire logic sys_rst,
  bdsl_if.device link,
  input wire logic irq_pending,
  input wire logic low_power,
  input wire logic system_stop,
  input wire logic step_done,
  input wire logic [7:0] read_data,
  output logic step_req,
  output logic step_irq_only,
  output logic enter_debug_req,
  output logic [7:0] cmd_code,
  output logic cmd_valid,
  output logic sync_seen,
  output logic soft_reset,
  output logic ack_enabled,
  output logic debug_active
);
  typedef enum logic [5:0] {
    st_idle = 6'b000001,
    st_low = 6'b000010,
    st_wait_high = 6'b000100,
    st_sync_wait = 6'b001000,
    st_sync_ans = 6'b010000,
    st_tx = 6'b100000
  } bdsl_state_t;

  bdsl_state_t state;
  logic pin;
  logic pin_q;
  logic [9:0] cnt;
  logic [9:0] idle_cnt;
  logic [2:0] bit_idx;
  logic [7:0] shreg;
  logic [7:0] tx_byte;
  logic tx_pending;
  logic step_lp;
  logic fall;
  logic rise;

  bdsl_sync u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .din(link.wire_level),
    .dout(pin)
  );

  assign fall = pin_q && !pin;
  assign rise = !pin_q && pin;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= pin;
    end
  end

  // bit engine
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= st_idle;
      cnt <= '0;
      idle_cnt <= '0;
      bit_idx <= '0;
      shreg <= '0;
      cmd_code <= '0;
      cmd_valid <= 1'b0;
      sync_seen <= 1'b0;
      soft_reset <= 1'b0;
      link.dev_out <= 1'b1;
      link.dev_oe <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      sync_seen <= 1'b0;
      soft_reset <= 1'b0;
      // counts from the last falling edge, held at zero through a timing request, saturates at the limit
      if (fall || state == st_sync_wait || state == st_sync_ans) begin
        idle_cnt <= '0; // R9
      end else if (idle_cnt != bdsl_pkg::timeout_cyc) begin
        idle_cnt <= idle_cnt + 10'h001;
      end
      case (state)
        st_idle: begin
          link.dev_oe <= 1'b0;
          if (fall) begin // R1
            cnt <= 10'h001;
            state <= tx_pending ? st_tx : st_low;
          end else if ((bit_idx != 3'h0 || tx_pending) && idle_cnt >= bdsl_pkg::timeout_cyc) begin
            bit_idx <= '0; // R9 R10
            soft_reset <= 1'b1;
          end
        end
        st_low: begin
          cnt <= cnt + 10'h001;
          if (cnt == bdsl_pkg::bit_sample_cyc) begin // R1
            shreg <= {shreg[6:0], pin};
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == bdsl_pkg::last_bit) begin
              cmd_code <= {shreg[6:0], pin};
              cmd_valid <= !system_stop; // R14
            end
            state <= st_wait_high;
          end
        end
        st_wait_high: begin
          cnt <= cnt + 10'h001;
          if (pin) begin
            state <= st_idle; // R8
          end else if (cnt > bdsl_pkg::sync_limit_cyc) begin
            state <= st_sync_wait; // R6
          end
        end
        st_sync_wait: begin
          if (rise) begin // R7
            bit_idx <= '0;
            cnt <= '0;
            state <= st_sync_ans;
          end
        end
        st_sync_ans: begin
          cnt <= cnt + 10'h001;
          link.dev_oe <= 1'b1; // R19
          link.dev_out <= 1'b0;
          if (cnt == bdsl_pkg::ack_low_cyc) begin
            link.dev_out <= 1'b1;
          end else if (cnt > bdsl_pkg::ack_low_cyc) begin
            link.dev_oe <= 1'b0;
            sync_seen <= 1'b1;
            state <= st_idle;
          end
        end
        st_tx: begin
          cnt <= cnt + 10'h001;
          if (cnt == bdsl_pkg::host_low_cyc) begin
            link.dev_oe <= !tx_byte[bdsl_pkg::last_bit - bit_idx]; // R19
            link.dev_out <= 1'b0;
          end else if (cnt == bdsl_pkg::speedup_cyc && tx_byte[bdsl_pkg::last_bit - bit_idx]) begin
            link.dev_oe <= 1'b1; // R4
            link.dev_out <= 1'b1;
          end else if (cnt == bdsl_pkg::bit_period_cyc - 10'h001 &&
                       !tx_byte[bdsl_pkg::last_bit - bit_idx]) begin
            // speedup only after a driven low
            link.dev_oe <= 1'b1;
            link.dev_out <= 1'b1;
          end else if (cnt >= bdsl_pkg::bit_period_cyc) begin
            link.dev_oe <= 1'b0;
            bit_idx <= bit_idx + 3'h1;
            state <= st_idle;
          end else if (cnt > bdsl_pkg::speedup_cyc) begin
            link.dev_oe <= link.dev_oe && !link.dev_out;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // read data holding
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tx_pending <= 1'b0;
      tx_byte <= '0;
    end else if (cmd_valid && cmd_code == bdsl_pkg::cmd_read && !system_stop) begin
      tx_pending <= 1'b1;
      tx_byte <= read_data;
    end else if (soft_reset) begin
      tx_pending <= 1'b0; // R10
    end else if (state == st_tx && cnt >= bdsl_pkg::bit_period_cyc &&
                 bit_idx == bdsl_pkg::last_bit) begin
      tx_pending <= 1'b0;
    end
  end

  // command execution and handshake
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      step_req <= 1'b0;
      step_irq_only <= 1'b0;
      enter_debug_req <= 1'b0;
      ack_enabled <= 1'b0;
      debug_active <= 1'b0;
      step_lp <= 1'b0;
    end else begin
      step_req <= 1'b0;
      enter_debug_req <= 1'b0;
      if (system_stop) begin
        ack_enabled <= 1'b0; // R17
      end else if (cmd_valid) begin // R14
        case (cmd_code)
          bdsl_pkg::cmd_ack_enable: ack_enabled <= 1'b1; // R16
          bdsl_pkg::cmd_ack_disable: ack_enabled <= 1'b0;
          bdsl_pkg::cmd_enter_debug: begin
            if (!low_power) begin // R13
              enter_debug_req <= 1'b1;
              debug_active <= 1'b1;
            end
          end
          bdsl_pkg::cmd_step: begin
            if (!low_power && debug_active) begin
              step_req <= 1'b1;
              step_irq_only <= irq_pending; // R11
              debug_active <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      if (step_done) begin
        if (low_power) begin
          step_lp <= 1'b1; // R12 R15
        end else begin
          debug_active <= 1'b1;
        end
      end else if (step_lp && !low_power) begin
        step_lp <= 1'b0; // R12
        debug_active <= 1'b1;
      end
    end
  end
endmodule : bdsl_device

//--- src/bdsl_pkg.sv
// shared constants for the single-wire debug link
package bdsl_pkg;
  localparam int unsigned clk_period_ns = 5;
  localparam int unsigned cnt_w = 10;
  localparam logic [9:0] bit_sample_cyc = 10'h00a;
  localparam logic [9:0] glitch_limit_cyc = 10'h008;
  localparam logic [9:0] host_low_cyc = 10'h002;
  localparam logic [9:0] speedup_cyc = 10'h007;
  localparam logic [9:0] host_sample_cyc = 10'h00a;
  // host pin lags the line by its synchroniser
  localparam logic [9:0] host_sync_lat_cyc = 10'h004;
  localparam logic [9:0] sync_limit_cyc = 10'h080;
  localparam logic [9:0] timeout_cyc = 10'h200;
  localparam logic [9:0] bit_period_cyc = 10'h010;
  localparam logic [9:0] host_zero_low_cyc = 10'h00d;
  localparam logic [9:0] sync_low_cyc = 10'h0a0;
  localparam logic [7:0] cmd_step = 8'h10;
  localparam logic [7:0] cmd_enter_debug = 8'h90;
  localparam logic [7:0] cmd_ack_enable = 8'hd5;
  localparam logic [7:0] cmd_ack_disable = 8'hd6;
  localparam logic [7:0] cmd_read = 8'he4;
  localparam logic [7:0] cmd_null = 8'h00;
  localparam logic [7:0] cmd_write = 8'hc4;
  localparam logic [9:0] ack_low_cyc = 10'h010;
  localparam logic [9:0] read_gap_cyc = 10'h010;
  localparam int unsigned byte_w = 8;
  localparam logic [2:0] last_bit = 3'h7;
endpackage : bdsl_pkg

//--- src/bdsl_if.sv
// single-wire debug line between host pod and target
interface bdsl_if;
  logic dev_out;
  logic dev_oe;
  logic host_out;
  logic host_oe;
  logic wire_level;
  // pulled up; low wins, speedup high drives high
  assign wire_level = (dev_oe && !dev_out) || (host_oe && !host_out) ? 1'b0 : 1'b1;
  modport device (output dev_out, output dev_oe, input wire_level);
  modport host (output host_out, output host_oe, input wire_level);
endinterface : bdsl_if

//--- src/bdsl_sync.sv
// three-stage synchroniser with second/third agreement
module bdsl_sync (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      dout <= 1'b1;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end
endmodule : bdsl_sync

//--- src/bdsl_host.sv
// host pod end of the single-wire debug link
module bdsl_host (
  input wire logic clk_sys,
  input wire logic sys_rst,
  bdsl_if.host link,
  input wire logic send_req,
  input wire logic [7:0] send_byte,
  input wire logic recv_req,
  input wire logic sync_req,
  output logic busy,
  output logic [7:0] recv_byte,
  output logic recv_valid
);
  logic pin;
  logic [9:0] cnt;
  logic [2:0] bit_idx;
  logic [7:0] sh;
  logic mode_rx;
  logic mode_sync;

  bdsl_sync u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .din(link.wire_level),
    .dout(pin)
  );

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busy <= 1'b0;
      cnt <= '0;
      bit_idx <= '0;
      sh <= '0;
      mode_rx <= 1'b0;
      mode_sync <= 1'b0;
      recv_byte <= '0;
      recv_valid <= 1'b0;
      link.host_out <= 1'b1;
      link.host_oe <= 1'b0;
    end else begin
      recv_valid <= 1'b0;
      if (!busy) begin
        if (send_req || recv_req || sync_req) begin
          busy <= 1'b1;
          sh <= send_byte;
          mode_rx <= recv_req;
          mode_sync <= sync_req;
          bit_idx <= '0;
          cnt <= '0;
          link.host_oe <= 1'b1; // R19
          link.host_out <= 1'b0;
        end
      end else begin
        cnt <= cnt + 10'h001;
        if (mode_sync) begin
          if (cnt == bdsl_pkg::sync_low_cyc) begin
            link.host_oe <= 1'b0;
          end else if (cnt > bdsl_pkg::sync_low_cyc + bdsl_pkg::timeout_cyc) begin
            busy <= 1'b0;
          end
        end else begin
          if (mode_rx && cnt == bdsl_pkg::host_low_cyc) begin
            link.host_oe <= 1'b0; // R3 R4
          end else if (!mode_rx && sh[7] && cnt == bdsl_pkg::host_low_cyc + 10'h002) begin
            link.host_oe <= 1'b1; // R2
            link.host_out <= 1'b1;
          end else if (!mode_rx && cnt == bdsl_pkg::host_zero_low_cyc) begin
            link.host_oe <= 1'b1;
            link.host_out <= 1'b1;
          end else if (cnt == bdsl_pkg::host_zero_low_cyc + 10'h001) begin
            link.host_oe <= 1'b0;
          end
          // line level near cycle ten, seen through the synchroniser
          if (mode_rx && cnt == bdsl_pkg::host_sample_cyc + bdsl_pkg::host_sync_lat_cyc) begin
            sh <= {sh[6:0], pin}; // R5
          end
          if (cnt == bdsl_pkg::bit_period_cyc + bdsl_pkg::read_gap_cyc) begin
            cnt <= '0;
            if (!mode_rx) begin
              sh <= {sh[6:0], 1'b0};
            end
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == bdsl_pkg::last_bit) begin
              busy <= 1'b0;
              recv_byte <= sh;
              recv_valid <= mode_rx;
            end else begin
              link.host_oe <= 1'b1;
              link.host_out <= 1'b0;
            end
          end
        end
      end
    end
  end
endmodule : bdsl_host

//--- tb/bdsl_assertions.sv
// wire-level checks on the single-wire debug link
module bdsl_assertions (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic host_out,
  input wire logic host_oe,
  input wire logic wire_level
);
  logic [9:0] low_run;
  logic [9:0] since_fall;
  logic [9:0] hlow;
  logic long_low;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk_sys) begin
    if (sys_rst || wire_level) low_run <= 10'h000;
    else if (low_run != 10'h3ff) low_run <= low_run + 10'h001;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) long_low <= 1'b0;
    else if (!wire_level) long_low <= (low_run >= 10'h080);
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst || $fell(wire_level)) since_fall <= 10'h000;
    else if (since_fall != 10'h3ff) since_fall <= since_fall + 10'h001;
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !(host_oe && !host_out)) hlow <= 10'h000;
    else if (hlow != 10'h3ff) hlow <= hlow + 10'h001;
  end
  a_speedup_brief: assert property (dev_oe && dev_out |=> !(dev_oe && dev_out))
    else $error("device high drive longer than one cycle");
  a_no_contention: assert property (!(dev_oe && host_oe))
    else $error("both ends drive the line");
  a_release_first: assert property ($rose(dev_oe) |-> !$past(host_oe, 2))
    else $error("device drives before host released");
  a_host_start_low: assert property ($rose(host_oe) |-> (host_oe && !host_out) [*2])
    else $error("host start low shorter than two cycles");
  a_host_low_len: assert property (host_oe && host_out && hlow != 10'h000 |->
    hlow inside {[2:8], [11:127]})
    else $error("host low time outside bit limits");
  a_sync_answer: assert property ($rose(wire_level) && long_low |->
    ##[1:8] (dev_oe && !dev_out))
    else $error("no answer to timing request");
  a_sync_high: assert property ($rose(wire_level) && long_low |-> ##[17:40] (dev_oe && dev_out))
    else $error("timing answer lacks high pulse");
  a_sync_wait: assert property (long_low && !wire_level && host_oe |-> !dev_oe)
    else $error("device answered before the rise");
  a_speedup_time: assert property ($rose(dev_oe) && dev_out && since_fall < 10'h040 |->
    since_fall inside {[6:14]})
    else $error("speedup pulse off its slot");
  c_sync: cover property ($rose(wire_level) && long_low);
  c_speedup: cover property (dev_oe && dev_out && since_fall < 10'h040);
  c_host_bit: cover property (host_oe && host_out && hlow == 10'h005);
endmodule : bdsl_assertions

//--- tb/tb_background_debug_serial_link.sv
// testbench joining both ends of the single-wire debug link
module tb_background_debug_serial_link;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, sys_rst = 1'b1;
  logic irq_pending = 1'b0, low_power = 1'b0, system_stop = 1'b0, step_done = 1'b0;
  logic send_req = 1'b0, recv_req = 1'b0, sync_req = 1'b0;
  logic [7:0] read_data = 8'h00, send_byte = 8'h00, rb;
  logic step_req, step_irq_only, enter_debug_req, cmd_valid, sync_seen, soft_reset;
  logic ack_enabled, debug_active, busy, recv_valid;
  logic [7:0] cmd_code, recv_byte;
  logic f_valid, f_step, f_enter, f_sync, f_soft;
  int mismatches = 0, n_tests = 0, cyc = 0;
  bdsl_if u_bdsl_if ();
  bdsl_device u_bdsl_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(u_bdsl_if),
    .irq_pending(irq_pending), .low_power(low_power), .system_stop(system_stop),
    .step_done(step_done), .read_data(read_data), .step_req(step_req),
    .step_irq_only(step_irq_only), .enter_debug_req(enter_debug_req), .cmd_code(cmd_code),
    .cmd_valid(cmd_valid), .sync_seen(sync_seen), .soft_reset(soft_reset),
    .ack_enabled(ack_enabled), .debug_active(debug_active));
  bdsl_host u_bdsl_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(u_bdsl_if),
    .send_req(send_req), .send_byte(send_byte), .recv_req(recv_req), .sync_req(sync_req),
    .busy(busy), .recv_byte(recv_byte), .recv_valid(recv_valid));
  bdsl_assertions u_bdsl_assertions (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .dev_out(u_bdsl_if.dev_out), .dev_oe(u_bdsl_if.dev_oe), .host_out(u_bdsl_if.host_out),
    .host_oe(u_bdsl_if.host_oe), .wire_level(u_bdsl_if.wire_level));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (cmd_valid === 1'b1) f_valid <= 1'b1;
    if (step_req === 1'b1) f_step <= 1'b1;
    if (enter_debug_req === 1'b1) f_enter <= 1'b1;
    if (sync_seen === 1'b1) f_sync <= 1'b1;
    if (soft_reset === 1'b1) f_soft <= 1'b1;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask : chk
  task idle_wait;
    tick(2);
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) tick(1);
    tick(20);
  endtask : idle_wait
  task send(input logic [7:0] b);
    {f_valid, f_step, f_enter, f_sync, f_soft} = 5'h00;
    send_byte = b;
    send_req = 1'b1;
    tick(1);
    send_req = 1'b0;
    idle_wait();
  endtask : send
  task t_read;
    read_data = 8'ha5;
    send(bdsl_pkg::cmd_read);
    chk(f_valid && cmd_code === bdsl_pkg::cmd_read, "read not decoded");
    recv_req = 1'b1;
    tick(1);
    recv_req = 1'b0;
    idle_wait();
    chk(recv_byte === 8'ha5, "read byte wrong");
    $display("t_read done");
  endtask : t_read
  task t_sync;
    f_sync = 1'b0;
    sync_req = 1'b1;
    tick(1);
    sync_req = 1'b0;
    idle_wait();
    chk(f_sync, "timing request not seen");
    $display("t_sync done");
  endtask : t_sync
  task t_step;
    send(bdsl_pkg::cmd_enter_debug);
    chk(f_enter && debug_active === 1'b1, "enter debug failed");
    irq_pending = 1'b1;
    send(bdsl_pkg::cmd_step);
    chk(f_step && step_irq_only === 1'b1, "step with irq not stack only");
    irq_pending = 1'b0;
    step_done = 1'b1;
    tick(1);
    step_done = 1'b0;
    send(bdsl_pkg::cmd_step);
    low_power = 1'b1;
    step_done = 1'b1;
    tick(1);
    step_done = 1'b0;
    tick(4);
    chk(debug_active === 1'b0, "debug entered in low power");
    send(bdsl_pkg::cmd_enter_debug);
    chk(f_enter === 1'b0, "enter debug taken in low power");
    send(bdsl_pkg::cmd_ack_enable);
    chk(f_valid && ack_enabled === 1'b1, "command lost in low power");
    low_power = 1'b0;
    tick(4);
    chk(debug_active === 1'b1, "debug not entered on exit");
    $display("t_step done");
  endtask : t_step
  task t_stop;
    system_stop = 1'b1;
    tick(3);
    chk(ack_enabled === 1'b0, "handshake kept in system stop");
    send(bdsl_pkg::cmd_ack_enable);
    chk(f_valid === 1'b0 && ack_enabled === 1'b0, "command run in system stop");
    system_stop = 1'b0;
    send(bdsl_pkg::cmd_ack_enable);
    chk(f_valid && ack_enabled === 1'b1, "handshake not re-enabled");
    $display("t_stop done");
  endtask : t_stop
  task t_timeout;
    send(bdsl_pkg::cmd_ack_disable);
    tick(600);
    chk(f_soft === 1'b0, "soft reset with nothing pending");
    send(bdsl_pkg::cmd_read);
    tick(600);
    chk(f_soft, "uncollected read not dropped");
    $display("t_timeout done");
  endtask : t_timeout
  task wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (10) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    tick(4);
    t_read();
    t_sync();
    t_step();
    t_stop();
    t_timeout();
    wrap_up();
  end
endmodule : tb_background_debug_serial_link
